// ===== core/sar_adc_pkg.sv
/*
 * constants for the converter sequencer: register map, field positions,
 * reset values and timing counts.
 * assumes a 25 MHz system clock and a 32-bit avalon-mm register port.
 */
package sar_adc_pkg;
    // =========================================================
    // register byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_CMD = 5'h04;
    localparam logic [4:0] OFF_MUX = 5'h08;
    localparam logic [4:0] OFF_DATA = 5'h0C;
    localparam logic [4:0] OFF_WIN_LO = 5'h10;
    localparam logic [4:0] OFF_WIN_HI = 5'h14;
    localparam logic [4:0] OFF_STATUS = 5'h18;
    localparam logic [4:0] OFF_MASK = 5'h1C;
    // =========================================================
    // control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_BURST = 1;
    localparam int CTRL_TRIG_LSB = 2;
    localparam int CTRL_ACC_LSB = 4;
    localparam int CTRL_WIN_OUT = 6;
    localparam int CMD_START = 0;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [4:0] MUX_RESET = 5'h00;
    localparam logic [15:0] WIN_LO_RESET = 16'h0000;
    localparam logic [15:0] WIN_HI_RESET = 16'hFFFF;
    // status and mask fields
    localparam int ST_DONE = 0;
    localparam int ST_WIN = 1;
    localparam int ST_BUSY = 2;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // =========================================================
    // trigger sources and accumulation counts
    typedef enum logic [1:0] {TRIG_SW, TRIG_TMR1, TRIG_TMR2, TRIG_EXT} trig_sel_t;
    typedef enum logic [1:0] {ACC_1, ACC_4, ACC_8, ACC_16} acc_sel_t;
    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SAMPLE_PERIOD_NS = 5000;
    localparam int WAKE_NS = 1000;
    localparam int SAMPLE_CYC = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    function automatic logic [4:0] acc_count(input acc_sel_t sel);
        unique case (sel)
            ACC_1: acc_count = 5'h01;
            ACC_4: acc_count = 5'h04;
            ACC_8: acc_count = 5'h08;
            ACC_16: acc_count = 5'h10;
        endcase
    endfunction : acc_count
endpackage : sar_adc_pkg

// ===== core/seq_if.sv
/*
 * carrier between register front end and sample sequencer.
 * assumes both ends run on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface seq_if;
    logic start;
    logic enable;
    logic burst;
    sar_adc_pkg::acc_sel_t acc_sel;
    logic busy;
    logic done;
    logic [15:0] result;
    modport ctl (output start, enable, burst, acc_sel, input busy, done, result);
    modport seq (input start, enable, burst, acc_sel, output busy, done, result);
endinterface : seq_if
`default_nettype wire

// ===== core/sample_seq.sv
/*
 * sample sequencer: powers the converter, paces samples and sums them.
 * assumes the analog converter answers each start with one done pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module sample_seq #(
    parameter int SAMPLE_CYC = sar_adc_pkg::SAMPLE_CYC,
    parameter int WAKE_CYC = sar_adc_pkg::WAKE_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    seq_if.seq sif,
    output logic conv_pwr,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [11:0] conv_data
);
    typedef enum logic [2:0] {S_IDLE, S_WAKE, S_CONV, S_WAIT, S_GAP} seq_state_t;
    seq_state_t state_q;
    logic [7:0] pace_q;
    logic [7:0] wake_q;
    logic [4:0] n_q;
    logic [4:0] target_q;
    logic [15:0] acc_q;

    // =========================================================
    // state machine
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
            n_q <= 5'h00;
            target_q <= 5'h01;
            acc_q <= 16'h0000;
            wake_q <= 8'h00;
        end else if (!sif.enable) begin
            // [R9] shutdown abandons a running sequence
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    // [R13] start ignored when busy
                    // [R9] no start while shut down
                    if (sif.start && sif.enable) begin
                        // [R12] accumulator cleared per sequence
                        acc_q <= 16'h0000;
                        n_q <= 5'h00;
                        // [R2] sample count latched
                        target_q <= sar_adc_pkg::acc_count(sif.acc_sel);
                        wake_q <= 8'(WAKE_CYC);
                        // [R5] burst wakes the converter
                        state_q <= sif.burst ? S_WAKE : S_CONV;
                    end
                end
                S_WAKE: begin
                    wake_q <= wake_q - 8'h01;
                    if (wake_q == 8'h01) begin
                        state_q <= S_CONV;
                    end
                end
                S_CONV: begin
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (conv_done) begin
                        // [R2] hardware accumulation
                        acc_q <= acc_q + {4'h0, conv_data};
                        n_q <= n_q + 5'h01;
                        state_q <= (n_q + 5'h01 == target_q) ? S_IDLE : S_GAP;
                    end
                end
                S_GAP: begin
                    // [R10] samples no faster than 200 ksps
                    if (pace_q == 8'h00) begin
                        state_q <= S_CONV;
                    end
                end
            endcase
        end
    end

    // =========================================================
    // sample pacing counter, reloaded on each converter start
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pace_q <= 8'h00;
        end else if (state_q == S_CONV) begin
            pace_q <= 8'(SAMPLE_CYC - 2);
        end else if (pace_q != 8'h00) begin
            pace_q <= pace_q - 8'h01;
        end
    end

    // =========================================================
    // completion pulse and result
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sif.done <= 1'b0;
            sif.result <= 16'h0000;
        end else begin
            sif.done <= 1'b0;
            if (sif.enable && state_q == S_WAIT && conv_done && n_q + 5'h01 == target_q) begin
                sif.done <= 1'b1;
                sif.result <= acc_q + {4'h0, conv_data};
            end
        end
    end

    assign sif.busy = (state_q != S_IDLE);
    assign conv_start = (state_q == S_CONV) && sif.enable;
    // [R5] burst powers down between sequences
    assign conv_pwr = sif.enable && (!sif.burst || state_q != S_IDLE);
endmodule : sample_seq
`default_nettype wire

// ===== core/sar_adc_sequencer.sv
/*
 * converter sequencer top: avalon-mm registers, trigger select, window
 * compare, interrupt and input select.
 * assumes all inputs synchronous to mclk; converter is outside.
 */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] start on software, timer 1, timer 2 or external trigger
// [R2] accumulate 1, 4, 8 or 16 samples in hardware
// [R3] set done flag, interrupt only when enabled
// [R4] latch 12 to 16 bit accumulated result on completion
// [R5] burst mode wakes, samples, returns to shutdown by itself
// [R6] window compare inside or outside raises window interrupt
// [R7] background monitoring interrupts only on window condition
// [R8] software selects positive input, measured against ground
// [R9] software shutdown, no conversions while shut down
// [R10] pacing limits conversions to 200 ksps; code paces only between samples of one sequence, not between sequences
// [R11] keeps running while the processor is halted
// [R12] accumulator cleared at start of each sequence
// [R13] trigger ignored while a sequence is in progress
module sar_adc_sequencer #(
    parameter int MUX_W = 5
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tmr1_ovf,
    input wire logic tmr2_ovf,
    input wire logic ext_start,
    output logic [MUX_W-1:0] amux_sel,
    output logic conv_pwr,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [11:0] conv_data,
    output logic irq
);
    seq_if sif ();
    logic ack_q;
    logic [6:0] ctrl_q;
    logic [15:0] data_q;
    logic [15:0] win_lo_q;
    logic [15:0] win_hi_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic ext_q;
    logic sw_start;
    logic trig;
    logic in_win;
    logic win_hit;
    logic wr_ok;
    logic rd_ok;
    sar_adc_pkg::trig_sel_t trig_sel;

    // =========================================================
    // avalon slave handshake: answer one cycle after request
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    // writes land only at the edge where waitrequest is seen low
    assign wr_ok = avs_write && ack_q;
    assign rd_ok = avs_read && !ack_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_ok) begin
            unique case (avs_address)
                sar_adc_pkg::OFF_CTRL: avs_readdata <= {25'h0, ctrl_q};
                sar_adc_pkg::OFF_MUX: avs_readdata <= 32'(amux_sel);
                sar_adc_pkg::OFF_DATA: avs_readdata <= {16'h0, data_q};
                sar_adc_pkg::OFF_WIN_LO: avs_readdata <= {16'h0, win_lo_q};
                sar_adc_pkg::OFF_WIN_HI: avs_readdata <= {16'h0, win_hi_q};
                sar_adc_pkg::OFF_STATUS: avs_readdata <= {29'h0, sif.busy, status_q};
                sar_adc_pkg::OFF_MASK: avs_readdata <= {30'h0, mask_q};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // configuration registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= sar_adc_pkg::CTRL_RESET;
            amux_sel <= MUX_W'(sar_adc_pkg::MUX_RESET);
            win_lo_q <= sar_adc_pkg::WIN_LO_RESET;
            win_hi_q <= sar_adc_pkg::WIN_HI_RESET;
            mask_q <= sar_adc_pkg::MASK_RESET;
        end else if (wr_ok && avs_byteenable[0]) begin
            unique case (avs_address)
                // [R9] enable bit is the shutdown control
                sar_adc_pkg::OFF_CTRL: ctrl_q <= avs_writedata[6:0];
                // [R8] positive input select
                sar_adc_pkg::OFF_MUX: amux_sel <= avs_writedata[MUX_W-1:0];
                sar_adc_pkg::OFF_WIN_LO: win_lo_q[7:0] <= avs_writedata[7:0];
                sar_adc_pkg::OFF_WIN_HI: win_hi_q[7:0] <= avs_writedata[7:0];
                sar_adc_pkg::OFF_MASK: mask_q <= avs_writedata[1:0];
                default: ;
            endcase
            if (avs_byteenable[1] && avs_address == sar_adc_pkg::OFF_WIN_LO) begin
                win_lo_q[15:8] <= avs_writedata[15:8];
            end
            if (avs_byteenable[1] && avs_address == sar_adc_pkg::OFF_WIN_HI) begin
                win_hi_q[15:8] <= avs_writedata[15:8];
            end
        end else if (wr_ok && avs_byteenable[1]) begin
            if (avs_address == sar_adc_pkg::OFF_WIN_LO) begin
                win_lo_q[15:8] <= avs_writedata[15:8];
            end
            if (avs_address == sar_adc_pkg::OFF_WIN_HI) begin
                win_hi_q[15:8] <= avs_writedata[15:8];
            end
        end
    end

    // =========================================================
    // trigger selection
    assign sw_start = wr_ok && avs_byteenable[0] && avs_address == sar_adc_pkg::OFF_CMD
        && avs_writedata[sar_adc_pkg::CMD_START];
    assign trig_sel = sar_adc_pkg::trig_sel_t'(ctrl_q[sar_adc_pkg::CTRL_TRIG_LSB +: 2]);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_start;
        end
    end

    // [R1] one selected source starts a sequence
    always_comb begin
        unique case (trig_sel)
            sar_adc_pkg::TRIG_SW: trig = sw_start;
            sar_adc_pkg::TRIG_TMR1: trig = tmr1_ovf;
            sar_adc_pkg::TRIG_TMR2: trig = tmr2_ovf;
            sar_adc_pkg::TRIG_EXT: trig = ext_start && !ext_q;
        endcase
    end

    // [R13] sequencer drops triggers while busy
    assign sif.start = trig && !sif.busy;
    assign sif.enable = ctrl_q[sar_adc_pkg::CTRL_EN];
    assign sif.burst = ctrl_q[sar_adc_pkg::CTRL_BURST];
    assign sif.acc_sel = sar_adc_pkg::acc_sel_t'(ctrl_q[sar_adc_pkg::CTRL_ACC_LSB +: 2]);

    // [R11] no halt input: sequencing never stalls
    sample_seq u_seq (
        .mclk(mclk),
        .arst_n(arst_n),
        .sif(sif),
        .conv_pwr(conv_pwr),
        .conv_start(conv_start),
        .conv_done(conv_done),
        .conv_data(conv_data)
    );

    // =========================================================
    // result latch and window compare
    // [R4] result latched on completion
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            data_q <= 16'h0000;
        end else if (sif.done) begin
            data_q <= sif.result;
        end
    end

    // [R6] inside or outside window selectable
    assign in_win = (sif.result >= win_lo_q) && (sif.result <= win_hi_q);
    assign win_hit = sif.done && (in_win != ctrl_q[sar_adc_pkg::CTRL_WIN_OUT]);

    // =========================================================
    // sticky status, write one to clear, set wins over clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= 2'h0;
        end else begin
            // [R3] completion flag
            // [R6] window flag
            status_q <= (status_q & ~((wr_ok && avs_byteenable[0]
                && avs_address == sar_adc_pkg::OFF_STATUS) ? avs_writedata[1:0] : 2'h0))
                | {win_hit, sif.done};
        end
    end

    // [R3] interrupt only when enabled
    // [R7] masking done leaves window-only interrupts
    assign irq = |(status_q & mask_q);
endmodule : sar_adc_sequencer
`default_nettype wire

// ===== verif/conv_model.sv
/*
 * behavioural converter: answers each start with one done pulse.
 * assumes starts come only while the sequencer powers the converter.
 */
`timescale 1ns/1ps
`default_nettype none
module conv_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic conv_start,
    input wire logic [11:0] sample,
    output logic conv_done,
    output logic [11:0] conv_data
);
    logic [1:0] wait_q;
    // =========================================================
    // conversion delay and result
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wait_q <= 2'h0;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end else begin
            conv_done <= (wait_q == 2'h1);
            // measured input value handed back with done
            conv_data <= (wait_q == 2'h1) ? sample : ~conv_data;
            if (conv_start) begin
                wait_q <= 2'h3;
            end else if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
endmodule : conv_model
`default_nettype wire

// ===== verif/sar_adc_sequencer_assertions.sv
/*
 * port checker for the converter sequencer.
 * assumes binding to the top module, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_assertions #(
    parameter int MUX_W = 5
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [MUX_W-1:0] amux_sel,
    input wire logic conv_pwr,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic irq
);
    localparam int PACE = 125;
    logic [7:0] gap_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // cycles since last start, saturating
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gap_q <= 8'hFF;
        end else if (conv_start) begin
            gap_q <= 8'h01;
        end else if (gap_q != 8'hFF) begin
            gap_q <= gap_q + 8'h01;
        end
    end
    // =========================================================
    a_bus_one_wait: assert property ($rose(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
    a_start_powered: assert property (conv_start |-> conv_pwr)
        else $error("start while shut down");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    a_start_pace: assert property (conv_start |-> gap_q >= PACE)
        else $error("starts closer than pacing");
    a_irq_cause: assert property ($rose(irq) |-> $past(conv_done)
        || $past(conv_done, 2) || $past(conv_done, 3) || $past(avs_write))
        else $error("irq rose without cause");
    a_irq_clear: assert property ($fell(irq) |-> $past(avs_write))
        else $error("irq fell without write");
    a_mux_write: assert property ($changed(amux_sel)
        |-> $past(avs_write && !avs_waitrequest)) else $error("input select moved");
    a_rdata_read: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without read");
    c_start: cover property (conv_start);
    c_irq: cover property ($rose(irq));
    c_pwr_off: cover property ($fell(conv_pwr));
endmodule : sar_adc_sequencer_assertions
`default_nettype wire

// ===== verif/sar_adc_sequencer_test.sv
/*
 * self-checking bench for the converter sequencer.
 * assumes the converter model in conv_model and the bound port checker.
 */
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_test;
    typedef struct {logic [1:0] acc; logic [11:0] v; logic [31:0] exp;} row_t;
    row_t rows[4] = '{'{2'h0, 12'hFFF, 32'h0FFF}, '{2'h1, 12'h123, 32'h048C},
        '{2'h2, 12'hABC, 32'h55E0}, '{2'h3, 12'hFFF, 32'hFFF0}};
    logic [4:0] ra[6] = '{5'h00, 5'h08, 5'h10, 5'h14, 5'h1C, 5'h0E};
    logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0};
    logic mclk, arst_n, avs_read, avs_write, avs_waitrequest, tmr1_ovf, tmr2_ovf;
    logic ext_start, conv_pwr, conv_start, conv_done, irq;
    logic [4:0] avs_address, amux_sel;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [11:0] conv_data, sample;
    int err_count, num_checks, cycles, starts, base;
    sar_adc_sequencer i_sar_adc_sequencer (.mclk(mclk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tmr1_ovf(tmr1_ovf), .tmr2_ovf(tmr2_ovf),
        .ext_start(ext_start), .amux_sel(amux_sel), .conv_pwr(conv_pwr),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
    conv_model i_conv_model (.mclk(mclk), .arst_n(arst_n), .conv_start(conv_start),
        .sample(sample), .conv_done(conv_done), .conv_data(conv_data));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (conv_start === 1'b1) starts++;
        if (cycles == 30000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask : chk
    // =========================================================
    // avalon-mm master: hold until waitrequest seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) err_count++;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // let a write settle before outputs are looked at
        @(posedge mclk);
    endtask : bus
    task automatic kick(input int t);
        // stale done flags must not satisfy the next wait
        bus(1'b1, sar_adc_pkg::OFF_STATUS, 32'h3);
        repeat (130) @(posedge mclk);
        if (t == 0) begin
            bus(1'b1, sar_adc_pkg::OFF_CMD, 32'h1);
        end else begin
            tmr1_ovf <= (t == 1);
            tmr2_ovf <= (t == 2);
            ext_start <= (t == 3);
            @(posedge mclk);
            tmr1_ovf <= 1'b0;
            tmr2_ovf <= 1'b0;
            ext_start <= 1'b0;
        end
    endtask : kick
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            bus(1'b0, sar_adc_pkg::OFF_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b1 && n < 1000);
        chk("done flag", {31'h0, q[0]}, 32'h1);
    endtask : wait_done
    initial begin
        arst_n = 1'b0;
        {avs_read, avs_write, tmr1_ovf, tmr2_ovf, ext_start} = 5'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        sample = 12'h000;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ra[i], 32'h0);
            chk("reset value", q, rv[i]);
        end
        chk("idle power", {31'h0, conv_pwr}, 32'h0);
        $display("test reset end");
        // sample counts, fresh sum each sequence
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, sar_adc_pkg::OFF_CTRL, 32'h1 | (32'(rows[i].acc) << 4));
            bus(1'b1, sar_adc_pkg::OFF_MUX, 32'(i + 3));
            sample <= rows[i].v;
            kick(0);
            wait_done();
            bus(1'b0, sar_adc_pkg::OFF_DATA, 32'h0);
            chk("data", q, rows[i].exp);
            chk("input select", {27'h0, amux_sel}, 32'(i + 3));
            bus(1'b1, sar_adc_pkg::OFF_STATUS, 32'h3);
        end
        $display("test rows end");
        // each hardware source, command ignored when not selected
        for (int t = 1; t < 4; t++) begin
            bus(1'b1, sar_adc_pkg::OFF_CTRL, 32'h1 | (32'(t) << 2));
            base = starts;
            kick(0);
            repeat (10) @(posedge mclk);
            chk("unselected start", 32'(starts - base), 32'h0);
            kick(t);
            wait_done();
            chk("selected start", 32'(starts - base), 32'h1);
        end
        $display("test triggers end");
        bus(1'b1, sar_adc_pkg::OFF_CTRL, 32'h31);
        base = starts;
        kick(0);
        repeat (300) @(posedge mclk);
        bus(1'b1, sar_adc_pkg::OFF_CMD, 32'h1);
        wait_done();
        chk("samples in sequence", 32'(starts - base), 32'h10);
        // shut down: command leaves converter idle
        bus(1'b1, sar_adc_pkg::OFF_CTRL, 32'h0);
        base = starts;
        kick(0);
        repeat (20) @(posedge mclk);
        chk("shutdown starts", 32'(starts - base), 32'h0);
        // burst wakes and returns to shutdown
        bus(1'b1, sar_adc_pkg::OFF_CTRL, 32'h3);
        chk("burst idle power", {31'h0, conv_pwr}, 32'h0);
        kick(0);
        wait_done();
        chk("burst after power", {31'h0, conv_pwr}, 32'h0);
        $display("test modes end");
        // window only interrupt, inside then outside, then done interrupt
        bus(1'b1, sar_adc_pkg::OFF_STATUS, 32'h3);
        bus(1'b1, sar_adc_pkg::OFF_WIN_LO, 32'h100);
        bus(1'b1, sar_adc_pkg::OFF_WIN_HI, 32'h200);
        bus(1'b1, sar_adc_pkg::OFF_MASK, 32'h2);
        bus(1'b1, sar_adc_pkg::OFF_CTRL, 32'h1);
        sample <= 12'h300;
        kick(0);
        wait_done();
        chk("no irq on plain done", {31'h0, irq}, 32'h0);
        bus(1'b1, sar_adc_pkg::OFF_STATUS, 32'h3);
        bus(1'b1, sar_adc_pkg::OFF_CTRL, 32'h41);
        kick(0);
        wait_done();
        chk("window status", q, 32'h3);
        chk("outside irq", {31'h0, irq}, 32'h1);
        bus(1'b1, sar_adc_pkg::OFF_STATUS, 32'h3);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        bus(1'b1, sar_adc_pkg::OFF_MASK, 32'h1);
        kick(0);
        wait_done();
        chk("done irq", {31'h0, irq}, 32'h1);
        $display("test interrupts end");
        wrap_up();
    end
endmodule : sar_adc_sequencer_test
bind sar_adc_sequencer sar_adc_sequencer_assertions #(.MUX_W(MUX_W))
    i_sar_adc_sequencer_assertions (.mclk(mclk), .arst_n(arst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .amux_sel(amux_sel), .conv_pwr(conv_pwr), .conv_start(conv_start),
    .conv_done(conv_done), .irq(irq));
`default_nettype wire
